// ---- hw/sfc_consts.svh ----
// Purpose: Offsets, field positions, reset values and timing counts of the sequencer
// Assumes: Byte addresses on a 32-bit AXI4-Lite bus
// Notes: Definitions only
`ifndef SFC_CONSTS_SVH
`define SFC_CONSTS_SVH

`define SFC_ADDR_MODE 8'h00
`define SFC_ADDR_FILTER 8'h04
`define SFC_ADDR_STATUS 8'h08
`define SFC_ADDR_DATA 8'h0C
`define SFC_ADDR_OFFSET 8'h10
`define SFC_ADDR_GAIN 8'h14
`define SFC_ADDR_INT_STS 8'h18
`define SFC_ADDR_INT_MASK 8'h1C

`define SFC_MODE_LSB 0
`define SFC_RANGE_LSB 4
`define SFC_AC_BIT 6
`define SFC_CHAN_LSB 8
`define SFC_CHOP_BIT 0
`define SFC_RATE_LSB 4

`define SFC_CHOP_RST 1'b1
`define SFC_RATE_RST 12'h010
`define SFC_OFFSET_NOMINAL 24'h800000
`define SFC_GAIN_NOMINAL 24'h400000

`define SFC_MOD_LAST 5'h1F
`define SFC_CAL_PERIODS_CHOP 6'h16
`define SFC_CAL_PERIODS_NOCHOP 6'h18
`define SFC_SETTLE_PERIODS 6'h03
`define SFC_TEST_CHAN 2'h2

`define SFC_INT_CAL 0
`define SFC_INT_DATA 1

`define SFC_RESP_OKAY 2'h0
`define SFC_RESP_SLVERR 2'h2

`endif

// ---- hw/sfc_pkg.sv ----
// Purpose: Types shared by the calibration sequencer and its coefficient store
// Assumes: Constants live in sfc_consts.svh
// Notes: Gray codes along idle, arm, calibrate
package sfc_pkg;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_ARM = 3'h1,
        ST_CAL = 3'h3,
        ST_CONV = 3'h2,
        ST_STBY = 3'h6
    } sfc_state_e;

    typedef enum logic [2:0] {
        MD_IDLE = 3'h0,
        MD_CONT = 3'h1,
        MD_SINGLE = 3'h2,
        MD_STBY = 3'h3,
        MD_SYS_ZERO = 3'h6,
        MD_SYS_FULL = 3'h7
    } sfc_mode_e;

    typedef struct packed {
        logic [1:0] inputRangeBits;
        logic excitationAcSelect;
        logic chopEnable;
        logic negInputShort;
        logic [1:0] channel;
    } sfc_afe_s;

    typedef struct packed {
        logic we;
        logic [2:0] addr;
        logic [23:0] data;
    } sfc_coef_wr_s;

    typedef logic [7:0][23:0] sfc_coef_arr_t;

    typedef struct packed {
        sfc_state_e state;
        logic [2:0] modeSelectBits;
        logic [1:0] inputRangeBits;
        logic acSel;
        logic [1:0] chanSel;
        logic chopEnable;
        logic [11:0] rateDiv;
        logic [4:0] modCnt;
        logic [11:0] rateCnt;
        logic [5:0] periodCnt;
        logic singleShot;
        logic readyN;
        logic [23:0] data;
        logic [1:0] intSts;
        logic [1:0] intMask;
        logic [7:0] awAddr;
        logic awHave;
        logic [31:0] wData;
        logic [3:0] wStrb;
        logic wHave;
        logic bValid;
        logic [1:0] bResp;
        logic rStage;
        logic [7:0] rAddr;
        logic rValid;
        logic [31:0] rData;
        logic [1:0] rResp;
    } sfc_state_s;

endpackage : sfc_pkg

// ---- hw/sfc_coef_mem.sv ----
// Purpose: Offset and gain coefficient store, one pair per channel
// Assumes: Even word is offset, odd word is gain
// Notes: Read data come out of a register one cycle after the address
`timescale 1ns/1ps
`include "sfc_consts.svh"

module sfc_coef_mem (
    input wire logic clk,
    input wire logic reset_n,
    input sfc_pkg::sfc_coef_wr_s wr,
    input wire logic [2:0] rdAddr,
    output logic [23:0] rdData
);

    typedef struct packed {
        sfc_pkg::sfc_coef_arr_t mem;
        logic [23:0] q;
    } sfc_mem_s;

    sfc_mem_s memReg;
    sfc_mem_s memNext;

    always_comb begin
        memNext = memReg;
        memNext.q = memReg.mem[rdAddr];
        if (wr.we) begin
            memNext.mem[wr.addr] = wr.data;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            // Nominal coefficients after reset
            for (int i = 0; i < 8; i++) begin
                memReg.mem[i] <= i[0] ? `SFC_GAIN_NOMINAL : `SFC_OFFSET_NOMINAL;
            end
            memReg.q <= 24'h000000;
        end else begin
            memReg <= memNext;
        end
    end

    assign rdData = memReg.q;

endmodule : sfc_coef_mem

// ---- hw/sfc_sequencer.sv ----
// Purpose: System calibration and conversion sequencer of a weigh-scale converter
// Assumes: clk is the master clock; filterWord is the filter output on clk
// Notes: Registers reached over AXI4-Lite
//
// Operation
// - Mode code 1,1,1 starts system full-scale calibration on selected channel.
// - Calibration uses the gain chosen by the input range bits.
// - Calibration excitation is ac when the ac select bit is set, else dc.
// - Calibration lasts 22 output periods with chop, 24 without.
// - At calibration end the mode field returns to 0,0,0.
// - Ready output high from calibration start until completion, then low.
// - Full-scale calibration writes only the channel gain; data register untouched.
// - Ready may rise up to one modulator cycle after the command.
// - Lone full-scale calibrations adjust gain only, leaving offset untouched.
// - Reset loads defaults and nominal calibration coefficients.
// - Chop enable chops the whole chain including first filter stage.
// - Test channel shorts the negative input to itself.
// - Mode code 1,1,0 runs system zero-scale calibration into channel offset.
// - Mode code 0,1,0 converts once, then returns to idle after settling.
//
// Our own choices: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
`include "sfc_consts.svh"

module sfc_sequencer (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [23:0] filterWord,
    output sfc_pkg::sfc_afe_s afeCtrl,
    output logic readyN,
    output logic irq
);

    sfc_pkg::sfc_state_s s_reg;
    sfc_pkg::sfc_state_s s_next;
    sfc_pkg::sfc_coef_wr_s coefWr;
    logic [2:0] memRdAddr;
    logic [23:0] memRdData;
    logic modTick;
    logic outTick;
    logic calBusy;
    logic [5:0] calLast;
    logic [1:0] intSet;
    logic [1:0] intClr;
    logic [31:0] merged;

    ////////////////////////////////////////////////////////////////////////////////
    // Helpers

    function automatic logic [31:0] mergeBytes(input logic [31:0] old,
                                               input logic [31:0] din,
                                               input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[b*8 +: 8] = din[b*8 +: 8];
            end
        end
        return res;
    endfunction : mergeBytes

    function automatic logic [2:0] coefAddr(input logic [1:0] chan, input logic isGain);
        return {chan, isGain};
    endfunction : coefAddr

    function automatic logic [31:0] modeWord(input sfc_pkg::sfc_state_s st);
        logic [31:0] w;
        w = 32'h00000000;
        w[`SFC_MODE_LSB +: 3] = st.modeSelectBits;
        w[`SFC_RANGE_LSB +: 2] = st.inputRangeBits;
        w[`SFC_AC_BIT] = st.acSel;
        w[`SFC_CHAN_LSB +: 2] = st.chanSel;
        return w;
    endfunction : modeWord

    function automatic logic [31:0] filterRegWord(input sfc_pkg::sfc_state_s st);
        logic [31:0] w;
        w = 32'h00000000;
        w[`SFC_CHOP_BIT] = st.chopEnable;
        w[`SFC_RATE_LSB +: 12] = st.rateDiv;
        return w;
    endfunction : filterRegWord

    ////////////////////////////////////////////////////////////////////////////////
    // Coefficient store

    sfc_coef_mem sfc_coef_mem_inst (
        .clk(clk),
        .reset_n(reset_n),
        .wr(coefWr),
        .rdAddr(memRdAddr),
        .rdData(memRdData)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Next-state logic

    assign calBusy = (s_reg.state == sfc_pkg::ST_ARM) || (s_reg.state == sfc_pkg::ST_CAL);
    assign modTick = (s_reg.modCnt == `SFC_MOD_LAST);
    assign outTick = modTick && ((13'(s_reg.rateCnt) + 13'h0001) >= 13'(s_reg.rateDiv));
    // Period index at which a calibration ends
    assign calLast = s_reg.chopEnable ? (`SFC_CAL_PERIODS_CHOP - 6'h01)
                                      : (`SFC_CAL_PERIODS_NOCHOP - 6'h01);
    assign s_axi_awready = !s_reg.awHave && !s_reg.bValid;
    assign s_axi_wready = !s_reg.wHave && !s_reg.bValid;
    assign s_axi_arready = !s_reg.rStage && !s_reg.rValid;
    assign memRdAddr = coefAddr(s_reg.chanSel, s_axi_araddr == `SFC_ADDR_GAIN);

    always_comb begin
        s_next = s_reg;
        coefWr = '0;
        intSet = 2'h0;
        intClr = 2'h0;
        merged = 32'h00000000;
        s_next.modCnt = s_reg.modCnt + 5'h01;

        // Sequencer
        if (modTick && !outTick) begin
            s_next.rateCnt = s_reg.rateCnt + 12'h001;
        end else if (outTick) begin
            s_next.rateCnt = 12'h000;
        end
        case (s_reg.state)
            sfc_pkg::ST_ARM: begin
                // Ready rises at the next modulator cycle boundary
                if (modTick) begin
                    s_next.state = sfc_pkg::ST_CAL;
                    s_next.readyN = 1'b1;
                    s_next.rateCnt = 12'h000;
                    s_next.periodCnt = 6'h00;
                end
            end
            sfc_pkg::ST_CAL: begin
                if (outTick) begin
                    if (s_reg.periodCnt == calLast) begin
                        // Gain for 1,1,1, offset for 1,1,0; data kept
                        coefWr.we = 1'b1;
                        coefWr.addr = coefAddr(s_reg.chanSel,
                            s_reg.modeSelectBits == sfc_pkg::MD_SYS_FULL);
                        coefWr.data = filterWord;
                        // Mode cleared in the cycle ready falls
                        s_next.modeSelectBits = sfc_pkg::MD_IDLE;
                        s_next.readyN = 1'b0;
                        intSet[`SFC_INT_CAL] = 1'b1;
                        s_next.state = sfc_pkg::ST_IDLE;
                    end else begin
                        s_next.periodCnt = s_reg.periodCnt + 6'h01;
                    end
                end
            end
            sfc_pkg::ST_CONV: begin
                if (outTick) begin
                    if (s_reg.periodCnt < (`SFC_SETTLE_PERIODS - 6'h01)) begin
                        s_next.periodCnt = s_reg.periodCnt + 6'h01;
                    end else begin
                        s_next.data = filterWord;
                        s_next.readyN = 1'b0;
                        intSet[`SFC_INT_DATA] = 1'b1;
                        // One settled result, then idle
                        if (s_reg.singleShot) begin
                            s_next.modeSelectBits = sfc_pkg::MD_IDLE;
                            s_next.state = sfc_pkg::ST_IDLE;
                        end
                    end
                end
            end
            default: begin
            end
        endcase

        // Write channel
        if (s_axi_awvalid && s_axi_awready) begin
            s_next.awHave = 1'b1;
            s_next.awAddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            s_next.wHave = 1'b1;
            s_next.wData = s_axi_wdata;
            s_next.wStrb = s_axi_wstrb;
        end
        if (s_reg.bValid && s_axi_bready) begin
            s_next.bValid = 1'b0;
        end
        if (s_reg.awHave && s_reg.wHave && !s_reg.bValid) begin
            s_next.awHave = 1'b0;
            s_next.wHave = 1'b0;
            s_next.bValid = 1'b1;
            s_next.bResp = `SFC_RESP_OKAY;
            case (s_reg.awAddr)
                `SFC_ADDR_MODE: begin
                    // Mode and setup are frozen while a calibration runs
                    if (!calBusy) begin
                        merged = mergeBytes(modeWord(s_reg), s_reg.wData, s_reg.wStrb);
                        s_next.modeSelectBits = merged[`SFC_MODE_LSB +: 3];
                        s_next.inputRangeBits = merged[`SFC_RANGE_LSB +: 2];
                        s_next.acSel = merged[`SFC_AC_BIT];
                        s_next.chanSel = merged[`SFC_CHAN_LSB +: 2];
                        s_next.periodCnt = 6'h00;
                        s_next.rateCnt = 12'h000;
                        s_next.singleShot = 1'b0;
                        case (merged[`SFC_MODE_LSB +: 3])
                            sfc_pkg::MD_SYS_FULL, sfc_pkg::MD_SYS_ZERO: begin
                                s_next.state = sfc_pkg::ST_ARM;
                            end
                            sfc_pkg::MD_CONT: begin
                                s_next.state = sfc_pkg::ST_CONV;
                                s_next.readyN = 1'b1;
                            end
                            sfc_pkg::MD_SINGLE: begin
                                s_next.state = sfc_pkg::ST_CONV;
                                s_next.singleShot = 1'b1;
                                s_next.readyN = 1'b1;
                            end
                            sfc_pkg::MD_STBY: begin
                                s_next.state = sfc_pkg::ST_STBY;
                                s_next.readyN = 1'b1;
                            end
                            default: begin
                                s_next.state = sfc_pkg::ST_IDLE;
                            end
                        endcase
                    end
                end
                `SFC_ADDR_FILTER: begin
                    if (!calBusy) begin
                        merged = mergeBytes(filterRegWord(s_reg), s_reg.wData, s_reg.wStrb);
                        s_next.chopEnable = merged[`SFC_CHOP_BIT];
                        s_next.rateDiv = merged[`SFC_RATE_LSB +: 12];
                    end
                end
                `SFC_ADDR_OFFSET, `SFC_ADDR_GAIN: begin
                    if (!calBusy) begin
                        coefWr.we = 1'b1;
                        coefWr.addr = coefAddr(s_reg.chanSel, s_reg.awAddr == `SFC_ADDR_GAIN);
                        coefWr.data = s_reg.wData[23:0];
                    end
                end
                `SFC_ADDR_INT_STS: begin
                    if (s_reg.wStrb[0]) begin
                        intClr = s_reg.wData[1:0];
                    end
                end
                `SFC_ADDR_INT_MASK: begin
                    merged = mergeBytes({30'h00000000, s_reg.intMask}, s_reg.wData, s_reg.wStrb);
                    s_next.intMask = merged[1:0];
                end
                `SFC_ADDR_STATUS, `SFC_ADDR_DATA: begin
                end
                default: begin
                    s_next.bResp = `SFC_RESP_SLVERR;
                end
            endcase
        end
        // A new event beats a clear in the same cycle
        s_next.intSts = (s_reg.intSts & ~intClr) | intSet;

        // Read channel: address accepted, then coefficient read, then answer
        if (s_axi_arvalid && s_axi_arready) begin
            s_next.rStage = 1'b1;
            s_next.rAddr = s_axi_araddr;
        end
        if (s_reg.rStage) begin
            s_next.rStage = 1'b0;
            s_next.rValid = 1'b1;
            s_next.rResp = `SFC_RESP_OKAY;
            case (s_reg.rAddr)
                `SFC_ADDR_MODE: s_next.rData = modeWord(s_reg);
                `SFC_ADDR_FILTER: s_next.rData = filterRegWord(s_reg);
                `SFC_ADDR_STATUS: s_next.rData = {30'h00000000, calBusy, s_reg.readyN};
                `SFC_ADDR_DATA: s_next.rData = {8'h00, s_reg.data};
                `SFC_ADDR_OFFSET, `SFC_ADDR_GAIN: s_next.rData = {8'h00, memRdData};
                `SFC_ADDR_INT_STS: s_next.rData = {30'h00000000, s_reg.intSts};
                `SFC_ADDR_INT_MASK: s_next.rData = {30'h00000000, s_reg.intMask};
                default: begin
                    s_next.rData = 32'h00000000;
                    s_next.rResp = `SFC_RESP_SLVERR;
                end
            endcase
        end
        if (s_reg.rValid && s_axi_rready) begin
            s_next.rValid = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            // Defaults for every register
            s_reg <= '0;
            s_reg.state <= sfc_pkg::ST_IDLE;
            s_reg.readyN <= 1'b1;
            s_reg.chopEnable <= `SFC_CHOP_RST;
            s_reg.rateDiv <= `SFC_RATE_RST;
        end else begin
            s_reg <= s_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign s_axi_bvalid = s_reg.bValid;
    assign s_axi_bresp = s_reg.bResp;
    assign s_axi_rvalid = s_reg.rValid;
    assign s_axi_rdata = s_reg.rData;
    assign s_axi_rresp = s_reg.rResp;
    assign readyN = s_reg.readyN;
    assign irq = |(s_reg.intSts & s_reg.intMask);
    assign afeCtrl.inputRangeBits = s_reg.inputRangeBits;
    assign afeCtrl.excitationAcSelect = s_reg.acSel;
    assign afeCtrl.chopEnable = s_reg.chopEnable;
    assign afeCtrl.negInputShort = (s_reg.chanSel == `SFC_TEST_CHAN);
    assign afeCtrl.channel = s_reg.chanSel;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks

    logic [23:0] calCycles;
    logic [23:0] calExpect;

    always_ff @(posedge clk) begin
        if (!reset_n || s_reg.state != sfc_pkg::ST_CAL) begin
            calCycles <= 24'h000000;
        end else begin
            calCycles <= calCycles + 24'h000001;
        end
    end

    assign calExpect = 24'(({18'h00000, calLast} + 24'h000001)
                     * ((s_reg.rateDiv == 12'h000) ? 24'h000001 : {12'h000, s_reg.rateDiv})
                     * 24'h000020) - 24'h000001;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    a_cal_length: assert property (
        (s_reg.state == sfc_pkg::ST_CAL && s_next.state == sfc_pkg::ST_IDLE)
        |-> calCycles == calExpect)
        else $error("calibration length wrong");

    a_ready_rise_bound: assert property (
        $rose(s_reg.state == sfc_pkg::ST_ARM) |-> ##[1:32] (readyN && s_reg.state == sfc_pkg::ST_CAL))
        else $error("ready not raised within one modulator cycle");

    a_ready_cal_high: assert property (
        s_reg.state == sfc_pkg::ST_CAL |-> readyN)
        else $error("ready low during calibration");

    a_mode_held: assert property (
        calBusy |-> (s_reg.modeSelectBits == sfc_pkg::MD_SYS_FULL
                  || s_reg.modeSelectBits == sfc_pkg::MD_SYS_ZERO))
        else $error("calibration code lost early");

    a_mode_clear_end: assert property (
        (s_reg.state == sfc_pkg::ST_CAL && s_next.state == sfc_pkg::ST_IDLE)
        |=> (s_reg.modeSelectBits == sfc_pkg::MD_IDLE && $fell(readyN)))
        else $error("mode not idle when ready fell");

    a_data_frozen: assert property (
        calBusy |=> $stable(s_reg.data))
        else $error("data register changed by calibration");

    a_gain_only: assert property (
        (coefWr.we && s_reg.state == sfc_pkg::ST_CAL
         && s_reg.modeSelectBits == sfc_pkg::MD_SYS_FULL)
        |-> coefWr.addr == {s_reg.chanSel, 1'b1})
        else $error("full-scale calibration wrote a non-gain word");

    a_start_arms: assert property (
        (s_reg.awHave && s_reg.wHave && !s_reg.bValid && !calBusy
         && s_reg.awAddr == `SFC_ADDR_MODE && s_reg.wStrb[0]
         && s_reg.wData[2:0] == sfc_pkg::MD_SYS_FULL)
        |=> s_reg.state == sfc_pkg::ST_ARM ##1 calBusy)
        else $error("full-scale command did not start calibration");

    a_single_idle: assert property (
        (s_reg.state == sfc_pkg::ST_CONV && s_reg.singleShot && intSet[`SFC_INT_DATA])
        |=> (s_reg.state == sfc_pkg::ST_IDLE && !readyN))
        else $error("single conversion did not return to idle");

endmodule : sfc_sequencer

// ---- verification/sfc_filter_model.sv ----
// Purpose: Filter output source standing in for the analog front end
// Assumes: One clock domain
// Notes: Holds the applied input code steady until the bench changes it
`timescale 1ns/1ps
module sfc_filter_model (
    input wire logic clk,
    input wire logic [23:0] level,
    output logic [23:0] filterWord
);
    always_ff @(posedge clk) begin
        filterWord <= level;
    end
endmodule : sfc_filter_model

// ---- verification/tb_sfc_sequencer.sv ----
// Purpose: Register-level checks of the calibration sequencer
// Assumes: Rate field 1 keeps output periods at 32 cycles
// Notes: Every wait is bounded
`timescale 1ns/1ps
`include "sfc_consts.svh"
module tb_sfc_sequencer;
    logic clk, reset_n, awvalid, wvalid, bready, arvalid, rready, awready, wready;
    logic bvalid, arready, rvalid, readyN, irq;
    logic [7:0] awaddr, araddr;
    logic [3:0] wstrb;
    logic [31:0] wdata, rdata;
    logic [1:0] bresp, rresp;
    logic [23:0] level, filterWord;
    sfc_pkg::sfc_afe_s afeCtrl;
    int miscompares, samplesChecked, cycNow, t0, e;

    sfc_filter_model sfc_filter_model_inst (.clk(clk), .level(level), .filterWord(filterWord));
    sfc_sequencer sfc_sequencer_inst (.clk(clk), .reset_n(reset_n), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .filterWord(filterWord), .afeCtrl(afeCtrl),
        .readyN(readyN), .irq(irq));

    initial begin
        clk = 1'h0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) cycNow <= cycNow + 1;
    ////////////////////////////////////////////////////////////
    task automatic finish_test();
        $display("miscompares %0d samples_checked %0d", miscompares, samplesChecked);
        if (miscompares == 0 && samplesChecked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : finish_test

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        samplesChecked++;
        if (got !== exp) begin
            $display("Error %s expected %h seen %h", what, exp, got);
            miscompares++;
        end
    endtask : chk

    task automatic guard(input int n);
        if (n > 3000) begin
            chk("timeout", 0, 1);
            finish_test();
        end
    endtask : guard

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] exp);
        int n;
        n = 0;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        do begin
            @(posedge clk);
            n++;
            guard(n);
            if (awready) awvalid <= 1'h0;
            if (wready) wvalid <= 1'h0;
        end while (!bvalid);
        bready <= 1'h0;
        chk("bresp", exp, bresp);
    endtask : wr

    task automatic rdChk(input string what, input logic [7:0] a, input logic [31:0] exp);
        int n;
        n = 0;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        do begin
            @(posedge clk);
            n++;
            guard(n);
            if (arready) arvalid <= 1'h0;
        end while (!rvalid);
        rready <= 1'h0;
        chk(what, exp, rdata);
    endtask : rdChk

    task automatic waitReady(input logic v);
        int n;
        n = 0;
        while (readyN !== v) begin
            @(posedge clk);
            n++;
            guard(n);
        end
    endtask : waitReady
    ////////////////////////////////////////////////////////////
    initial begin
        {reset_n, awvalid, wvalid, bready, arvalid, rready} <= 6'h00;
        {awaddr, araddr, wdata} <= 48'h0;
        wstrb <= 4'hF;
        level <= 24'h123456;
        repeat (5) @(posedge clk);
        reset_n <= 1'h1;
        @(posedge clk);
        chk("readyN", 1, readyN);
        rdChk("mode", `SFC_ADDR_MODE, 0);
        rdChk("filter", `SFC_ADDR_FILTER, 32'h101);
        rdChk("offset", `SFC_ADDR_OFFSET, `SFC_OFFSET_NOMINAL);
        rdChk("gain", `SFC_ADDR_GAIN, `SFC_GAIN_NOMINAL);
        rdChk("unmapped", 8'h20, 0);
        chk("rresp", `SFC_RESP_SLVERR, rresp);
        wr(8'h24, 0, `SFC_RESP_SLVERR);
        wr(`SFC_ADDR_FILTER, 32'h11, `SFC_RESP_OKAY);
        wr(`SFC_ADDR_MODE, 32'h6, `SFC_RESP_OKAY);
        waitReady(1'h1);
        waitReady(1'h0);
        rdChk("offset", `SFC_ADDR_OFFSET, 32'h123456);
        chk("irq", 0, irq);
        wr(`SFC_ADDR_INT_MASK, 32'h1, `SFC_RESP_OKAY);
        chk("irq", 1, irq);
        wr(`SFC_ADDR_INT_STS, 32'h1, `SFC_RESP_OKAY);
        chk("irq", 0, irq);
        for (int c = 1; c >= 0; c--) begin
            level <= 24'h2A0000 + 24'(c);
            wr(`SFC_ADDR_FILTER, 32'h10 | 32'(c), `SFC_RESP_OKAY);
            wr(`SFC_ADDR_MODE, 32'h77, `SFC_RESP_OKAY);
            t0 = cycNow;
            waitReady(1'h1);
            chk("rise", 1, cycNow - t0 <= 33);
            t0 = cycNow;
            wr(`SFC_ADDR_MODE, 32'h1, `SFC_RESP_OKAY);
            wr(`SFC_ADDR_OFFSET, 0, `SFC_RESP_OKAY);
            rdChk("mode", `SFC_ADDR_MODE, 32'h77);
            rdChk("status", `SFC_ADDR_STATUS, 32'h3);
            chk("short", 0, afeCtrl.negInputShort);
            chk("range", 3, afeCtrl.inputRangeBits);
            chk("ac", 1, afeCtrl.excitationAcSelect);
            chk("chop", c, afeCtrl.chopEnable);
            waitReady(1'h0);
            e = (c == 1 ? 22 : 24) * 32;
            chk("length", 1, cycNow - t0 >= e - 1 && cycNow - t0 <= e + 1);
            rdChk("mode", `SFC_ADDR_MODE, 32'h70);
            rdChk("status", `SFC_ADDR_STATUS, 0);
            rdChk("gain", `SFC_ADDR_GAIN, 32'h2A0000 + c);
            rdChk("offset", `SFC_ADDR_OFFSET, 32'h123456);
            rdChk("data", `SFC_ADDR_DATA, 0);
        end
        level <= 24'h0ABCDE;
        wr(`SFC_ADDR_MODE, 32'h202, `SFC_RESP_OKAY);
        chk("short", 1, afeCtrl.negInputShort);
        chk("channel", 2, afeCtrl.channel);
        waitReady(1'h0);
        rdChk("data", `SFC_ADDR_DATA, 32'h0ABCDE);
        rdChk("mode", `SFC_ADDR_MODE, 32'h200);
        rdChk("intsts", `SFC_ADDR_INT_STS, 32'h3);
        chk("irq", 1, irq);
        level <= 24'h054321;
        wstrb <= 4'h1;
        wr(`SFC_ADDR_MODE, 32'hFF01, `SFC_RESP_OKAY);
        wstrb <= 4'hF;
        waitReady(1'h0);
        rdChk("data", `SFC_ADDR_DATA, 32'h054321);
        rdChk("mode", `SFC_ADDR_MODE, 32'h201);
        wr(`SFC_ADDR_MODE, 32'h203, `SFC_RESP_OKAY);
        chk("readyN", 1, readyN);
        rdChk("mode", `SFC_ADDR_MODE, 32'h203);
        finish_test();
    end
endmodule : tb_sfc_sequencer
